// ### pmap_mapper.sv
// program rom paging and data rom window mapper between core and rom
//
// Operation
// [RULE_01] core program addresses are twelve bits
// [RULE_02] twelve-bit program counter drives untranslated address
// [RULE_03] top twelve vector bytes always reachable
// [RULE_04] only 0..7ff banked, upper half fixed
// [RULE_05] program memory grows in 2 kbyte banks
// [RULE_06] 256-byte data space, 64-byte window
// [RULE_07] data reads 40h..7fh return rom bytes
// [RULE_08] low six data bits form low rom bits
// [RULE_09] window register supplies upper rom bits
// [RULE_10] other data addresses bypass the window
// [RULE_11] lower half: bank above eleven low bits
// [RULE_12] bank and window cleared by reset
`timescale 1ns/1ps
module pmap_mapper #(
	parameter int ROM_AW = pmap_pkg::ROM_AW_DEF
) (
	input wire logic core_clk,
	input wire logic arst_n,
	// instruction fetch side
	input wire logic fetch_req,
	input wire logic [pmap_pkg::PC_W-1:0] fetch_pc,
	output logic fetch_ready,
	output logic fetch_valid,
	output logic [pmap_pkg::DATA_W-1:0] fetch_data,
	// data read side
	input wire logic drd_req,
	input wire logic [pmap_pkg::DADDR_W-1:0] drd_addr,
	output logic drd_ready,
	output logic drd_valid,
	output logic [pmap_pkg::DATA_W-1:0] drd_data,
	output logic ram_sel,
	// core writes to the bank and window registers
	input wire logic bank_wr,
	input wire logic [ROM_AW-pmap_pkg::HALF_BIT-1:0] bank_wdata,
	input wire logic win_wr,
	input wire logic [ROM_AW-pmap_pkg::WIN_OFF_W-1:0] win_wdata,
	// current selections, visible to the core for read-back
	output logic [ROM_AW-pmap_pkg::HALF_BIT-1:0] bank_sel,
	output logic [ROM_AW-pmap_pkg::WIN_OFF_W-1:0] win_sel,
	// program rom port, one cycle read latency
	output logic rom_en,
	output logic [ROM_AW-1:0] rom_addr,
	input wire logic [pmap_pkg::DATA_W-1:0] rom_rdata
);

	// [RULE_05] one bank bit per rom address bit above the eleven-bit 2 kbyte bank offset
	localparam int BANK_W = ROM_AW - pmap_pkg::HALF_BIT;
	// [RULE_09] six bits for 4 kbyte rom, seven for 8 kbyte
	localparam int WIN_W = ROM_AW - pmap_pkg::WIN_OFF_W;

	//////////////////////////////////////////////////////////////////
	// module state
	typedef struct packed {
		pmap_pkg::pmap_state_t state; // sequencer
		logic [BANK_W-1:0] bank; // paged-half selection
		logic [WIN_W-1:0] win; // data rom window selection
		logic rom_en; // rom read strobe
		logic [ROM_AW-1:0] rom_addr; // physical rom address
		logic fvalid; // fetch answer pulse
		logic [pmap_pkg::DATA_W-1:0] fdata; // fetched byte
		logic dvalid; // window read answer pulse
		logic [pmap_pkg::DATA_W-1:0] ddata; // window byte
	} pmap_regs_t;

	pmap_regs_t s_q; // registered state
	pmap_regs_t s_d; // next state

	logic [ROM_AW-1:0] prog_addr; // translated fetch address
	logic [ROM_AW-1:0] wadr; // translated window address
	logic win_hit; // data address inside window
	logic idle; // no rom access in flight
	logic take_win; // window read accepted this cycle
	logic take_fetch; // fetch accepted this cycle

	//////////////////////////////////////////////////////////////////
	// translators
	pmap_bank_xlat #(
		.ROM_AW(ROM_AW)
	) u_bank_xlat (
		.pc(fetch_pc),
		.bank(s_q.bank),
		.rom_addr(prog_addr)
	);

	pmap_win_xlat #(
		.ROM_AW(ROM_AW)
	) u_win_xlat (
		.daddr(drd_addr),
		.win(s_q.win),
		.hit(win_hit),
		.rom_addr(wadr)
	);

	//////////////////////////////////////////////////////////////////
	// handshakes: window reads win over fetches when both ask
	always_comb begin
		idle = (s_q.state == pmap_pkg::ST_IDLE);
		// [RULE_07] window read goes to rom
		take_win = idle && drd_req && win_hit;
		take_fetch = idle && fetch_req && !(drd_req && win_hit);
		fetch_ready = idle && !(drd_req && win_hit);
		// ram reads never wait on the rom sequencer
		drd_ready = idle || !win_hit;
		// [RULE_10] outside window decoded normally
		ram_sel = drd_req && !win_hit;
	end

	//////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_d = s_q;
		s_d.rom_en = 1'b0;
		s_d.fvalid = 1'b0;
		s_d.dvalid = 1'b0;
		// selections load straight from core writes
		if (bank_wr) begin
			s_d.bank = bank_wdata;
		end
		if (win_wr) begin
			s_d.win = win_wdata;
		end
		case (s_q.state)
			pmap_pkg::ST_IDLE: begin
				if (take_win) begin
					// [RULE_08] window address to rom
					s_d.rom_addr = wadr;
					s_d.rom_en = 1'b1;
					s_d.state = pmap_pkg::ST_WRD;
				end else if (take_fetch) begin
					// [RULE_04] banked or fixed fetch
					s_d.rom_addr = prog_addr;
					s_d.rom_en = 1'b1;
					s_d.state = pmap_pkg::ST_FRD;
				end
			end
			pmap_pkg::ST_FRD: begin
				// rom answers the cycle after the strobe, so the strobe cycle only waits;
				// sampling in the strobe cycle would hand the core a stale byte
				if (!s_q.rom_en) begin
					s_d.fdata = rom_rdata;
					s_d.fvalid = 1'b1;
					s_d.state = pmap_pkg::ST_IDLE;
				end
			end
			pmap_pkg::ST_WRD: begin
				// same one-cycle wait as a fetch
				if (!s_q.rom_en) begin
					s_d.ddata = rom_rdata;
					s_d.dvalid = 1'b1;
					s_d.state = pmap_pkg::ST_IDLE;
				end
			end
			default: begin
				// unreachable codes fall back to idle
				s_d.state = pmap_pkg::ST_IDLE;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			// [RULE_12] clear bank and window
			s_q <= '{
				state: pmap_pkg::ST_IDLE,
				bank: BANK_W'(pmap_pkg::SEL_RST),
				win: WIN_W'(pmap_pkg::SEL_RST),
				rom_en: 1'b0,
				rom_addr: '0,
				fvalid: 1'b0,
				fdata: '0,
				dvalid: 1'b0,
				ddata: '0
			};
		end else begin
			s_q <= s_d;
		end
	end

	//////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops
	always_comb begin
		rom_en = s_q.rom_en;
		rom_addr = s_q.rom_addr;
		fetch_valid = s_q.fvalid;
		fetch_data = s_q.fdata;
		drd_valid = s_q.dvalid;
		drd_data = s_q.ddata;
		bank_sel = s_q.bank;
		win_sel = s_q.win;
	end

	//////////////////////////////////////////////////////////////////
	// checks

	// upper half must not move with the bank
	a_upper_fixed: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_04]
		take_fetch && fetch_pc[11] |=> rom_en && rom_addr == ROM_AW'($past(fetch_pc)))
		else $error("upper half fetch address was banked");

	// lower half carries the bank above eleven bits
	a_lower_banked: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_11]
		take_fetch && !fetch_pc[11] |=>
		rom_addr == {$past(s_q.bank), $past(fetch_pc[10:0])})
		else $error("lower half fetch not formed from bank and pc");

	// vectors land at their own address in every bank
	a_vector_reach: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_03]
		take_fetch && fetch_pc >= pmap_pkg::VEC_BASE |=>
		rom_addr == ROM_AW'($past(fetch_pc)))
		else $error("vector fetch not at fixed location");

	// window read address built from window and low data bits
	a_win_addr: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_09]
		take_win |=> rom_en && rom_addr == {$past(s_q.win), $past(drd_addr[5:0])})
		else $error("window rom address wrong");

	// data outside the window never touches the rom
	a_win_bypass: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_10]
		drd_req && (drd_addr < 8'h40 || drd_addr > 8'h7f) |-> ram_sel && !take_win)
		else $error("data read outside window went to rom");

	// window byte comes back three edges after acceptance
	a_win_answer: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_07]
		take_win |-> ##1 !drd_valid ##1 !drd_valid ##1 drd_valid && drd_data == $past(rom_rdata))
		else $error("window read answer late or wrong");

	// fetch byte comes back three edges after acceptance
	a_fetch_answer: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_02]
		take_fetch |-> ##3 fetch_valid && fetch_data == $past(rom_rdata))
		else $error("fetch answer late or wrong");

	// bank write takes effect on the next cycle
	a_bank_load: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_05]
		bank_wr |=> bank_sel == $past(bank_wdata))
		else $error("bank register did not load");

	// window write takes effect on the next cycle
	a_win_load: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_06]
		win_wr |=> win_sel == $past(win_wdata))
		else $error("window register did not load");

	// rom strobe is a single-cycle pulse
	a_rom_pulse: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_01]
		rom_en |=> !rom_en)
		else $error("rom strobe held too long");

	//////////////////////////////////////////////////////////////////
	// handshake and hold checks

	// no new fetch while an access is in flight
	a_busy_refuse: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_02]
		take_fetch || take_win |=> !fetch_ready ##1 !fetch_ready)
		else $error("fetch offered while rom busy");

	// a window read asking blocks a fetch in the same cycle
	a_win_first: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_07]
		drd_req && drd_addr >= pmap_pkg::WIN_LO && drd_addr <= pmap_pkg::WIN_HI |-> !fetch_ready)
		else $error("fetch offered against a window read");

	// fetch answer is a single-cycle pulse
	a_fetch_pulse: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_02]
		fetch_valid |=> !fetch_valid)
		else $error("fetch answer held too long");

	// window answer is a single-cycle pulse
	a_drd_pulse: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_07]
		drd_valid |=> !drd_valid)
		else $error("window answer held too long");

	// fetched byte holds until the next answer
	a_fetch_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_02]
		!fetch_valid |-> $stable(fetch_data))
		else $error("fetched byte changed without an answer");

	// window byte holds until the next answer
	a_win_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_07]
		!drd_valid |-> $stable(drd_data))
		else $error("window byte changed without an answer");

	// rom address only moves together with a strobe
	a_addr_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_04]
		!rom_en |-> $stable(rom_addr))
		else $error("rom address moved without a strobe");

	// bank keeps its value without a write
	a_bank_keep: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_05]
		!bank_wr |=> $stable(bank_sel))
		else $error("bank register changed without a write");

	// window keeps its value without a write
	a_win_keep: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_09]
		!win_wr |=> $stable(win_sel))
		else $error("window register changed without a write");

	// a normal data read alone never strobes the rom
	a_ram_quiet: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_10]
		ram_sel && !take_fetch |=> !rom_en)
		else $error("normal data read strobed the rom");

endmodule : pmap_mapper

// ### pmap_pkg.sv
// shared constants and types for the program rom paging and data window mapper
package pmap_pkg;

	// core program address width and directly reachable space
	localparam int PC_W = 12;
	// bit that splits the paged lower half from the fixed upper half
	localparam int HALF_BIT = 11;
	// default physical rom address width (8 kbyte rom)
	localparam int ROM_AW_DEF = 13;
	// data space address width (256 locations)
	localparam int DADDR_W = 8;
	// low address bits that a window read takes from the data address
	localparam int WIN_OFF_W = 6;
	// data addresses that read through to program rom
	localparam logic [7:0] WIN_LO = 8'h40;
	localparam logic [7:0] WIN_HI = 8'h7f;
	// first of the twelve vector bytes at the top of program space
	localparam logic [11:0] VEC_BASE = 12'hff4;
	// reset value of the bank and window registers
	localparam logic [7:0] SEL_RST = 8'h00;
	// rom data width
	localparam int DATA_W = 8;

	// sequencer states, one rom access in flight at most
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FRD = 2'b01,
		ST_WRD = 2'b10
	} pmap_state_t;

	// true when a data address falls inside the rom window
	function automatic logic in_window(input logic [7:0] daddr);
		in_window = (daddr >= WIN_LO) && (daddr <= WIN_HI);
	endfunction : in_window

endpackage : pmap_pkg

// ### pmap_bank_xlat.sv
// program address translation: banked lower half, fixed upper half
`timescale 1ns/1ps
module pmap_bank_xlat #(
	parameter int ROM_AW = pmap_pkg::ROM_AW_DEF
) (
	input wire logic [pmap_pkg::PC_W-1:0] pc,
	input wire logic [ROM_AW-pmap_pkg::HALF_BIT-1:0] bank,
	output logic [ROM_AW-1:0] rom_addr
);
	// upper half keeps its own address, so the vectors never move
	localparam int BANK_W = ROM_AW - pmap_pkg::HALF_BIT;

	//////////////////////////////////////////////////////////////////
	// combinational mapping
	always_comb begin
		// [RULE_04] upper half fixed
		if (pc[pmap_pkg::HALF_BIT]) begin
			rom_addr = {{(ROM_AW - pmap_pkg::PC_W){1'b0}}, pc};
		end else begin
			// [RULE_11] bank over low bits
			rom_addr = {bank, pc[pmap_pkg::HALF_BIT-1:0]};
		end
	end

	// bank width must leave room for at least one paged bit
	if (BANK_W < 1) begin : g_bad_width
		$error("rom address width too small for paging");
	end

endmodule : pmap_bank_xlat

// ### pmap_win_xlat.sv
// data rom window translation: window register over low data bits
`timescale 1ns/1ps
module pmap_win_xlat #(
	parameter int ROM_AW = pmap_pkg::ROM_AW_DEF
) (
	input wire logic [pmap_pkg::DADDR_W-1:0] daddr,
	input wire logic [ROM_AW-pmap_pkg::WIN_OFF_W-1:0] win,
	output logic hit,
	output logic [ROM_AW-1:0] rom_addr
);

	//////////////////////////////////////////////////////////////////
	// combinational window decode and address build
	always_comb begin
		// [RULE_10] window range only
		hit = pmap_pkg::in_window(daddr);
		// [RULE_08] [RULE_09] window high, data low
		rom_addr = {win, daddr[pmap_pkg::WIN_OFF_W-1:0]};
	end

endmodule : pmap_win_xlat

// ### pmap_rom_model.sv
// program rom model answering one cycle after each read strobe
`timescale 1ns/1ps
module pmap_rom_model #(
	parameter int ROM_AW = 13
) (
	input wire logic core_clk,
	input wire logic rom_en,
	input wire logic [ROM_AW-1:0] rom_addr,
	output logic [7:0] rom_rdata
);
	////////////////////////////////////////////////////////////////
	// seeded so the idle toggle below starts from a known byte
	initial rom_rdata = 8'h00;
	// rom bytes for reads
	// data outside the answer cycle toggles, so a late sample cannot pass
	always @(posedge core_clk) begin
		if (rom_en) begin
			rom_rdata <= rom_addr[7:0] ^ 8'(rom_addr >> 8) ^ 8'h5a;
		end else begin
			rom_rdata <= ~rom_rdata;
		end
	end
endmodule : pmap_rom_model

// ### pmap_mapper_bench.sv
// self-checking bench for the paging and window mapper
`timescale 1ns/1ps
module pmap_mapper_bench;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic fetch_req = 1'b0;
	logic [11:0] fetch_pc = 12'h000;
	logic drd_req = 1'b0;
	logic [7:0] drd_addr = 8'h00;
	logic bank_wr = 1'b0;
	logic [1:0] bank_wdata = 2'h0;
	logic win_wr = 1'b0;
	logic [6:0] win_wdata = 7'h00;
	logic fetch_ready, fetch_valid, drd_ready, drd_valid, ram_sel, rom_en;
	logic [7:0] fetch_data, drd_data, rom_rdata;
	logic [1:0] bank_sel;
	logic [6:0] win_sel;
	logic [12:0] rom_addr;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	int seed;
	logic [11:0] pc;
	logic [6:0] w;
	////////////////////////////////////////////////////////////////
	pmap_mapper #(.ROM_AW(13)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
		.fetch_req(fetch_req), .fetch_pc(fetch_pc), .fetch_ready(fetch_ready),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data), .drd_req(drd_req),
		.drd_addr(drd_addr), .drd_ready(drd_ready), .drd_valid(drd_valid),
		.drd_data(drd_data), .ram_sel(ram_sel), .bank_wr(bank_wr),
		.bank_wdata(bank_wdata), .win_wr(win_wr), .win_wdata(win_wdata),
		.bank_sel(bank_sel), .win_sel(win_sel), .rom_en(rom_en),
		.rom_addr(rom_addr), .rom_rdata(rom_rdata));
	pmap_rom_model #(.ROM_AW(13)) rom_u (.core_clk(core_clk), .rom_en(rom_en),
		.rom_addr(rom_addr), .rom_rdata(rom_rdata));
	// 25 mhz clock
	always #20 core_clk = ~core_clk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	// hang guard, far above the fewer than two hundred cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// loads both selections, one strobe edge then one settle edge
	task automatic wr_sel(input logic [1:0] b, input logic [6:0] v);
		bank_wr <= 1'b1;
		win_wr <= 1'b1;
		bank_wdata <= b;
		win_wdata <= v;
		@(posedge core_clk);
		bank_wr <= 1'b0;
		win_wr <= 1'b0;
		@(posedge core_clk);
		chk("bank_sel", {11'h0, b}, {11'h0, bank_sel});
		chk("win_sel", {6'h0, v}, {6'h0, win_sel});
	endtask : wr_sel
	// one fetch or window read; checks physical address, byte and latency
	task automatic acc(input logic win, input logic [11:0] a, input logic [12:0] ea);
		logic [12:0] seen;
		int n;
		seen = 13'h1fff ^ ea;
		n = 0;
		if (win) begin
			drd_req <= 1'b1;
			drd_addr <= a[7:0];
		end else begin
			fetch_req <= 1'b1;
			fetch_pc <= a;
		end
		@(negedge core_clk);
		while ((win ? drd_ready : fetch_ready) !== 1'b1 && n < 9) begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		fetch_req <= 1'b0;
		drd_req <= 1'b0;
		for (n = 0; n < 4; n++) begin
			@(negedge core_clk);
			if (rom_en === 1'b1) seen = rom_addr;
			if ((win ? drd_valid : fetch_valid) === 1'b1) break;
		end
		chk("rom_addr", ea, seen);
		chk("latency", 13'h2, 13'(n));
		chk("data", {5'h0, ea[7:0] ^ {3'h0, ea[12:8]} ^ 8'h5a},
			{5'h0, win ? drd_data : fetch_data});
		@(posedge core_clk);
	endtask : acc
	initial begin
		seed = 32'ha61fad50;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		chk("bank_sel", 13'h0, {11'h0, bank_sel});
		chk("win_sel", 13'h0, {6'h0, win_sel});
		// every bank, with the half boundary on both sides
		for (int b = 0; b < 4; b++) begin
			wr_sel(2'(b), 7'h00);
			pc = 12'($random(seed)) & 12'h7ff;
			acc(1'b0, pc, {2'(b), pc[10:0]});
			acc(1'b0, 12'h7ff, {2'(b), 11'h7ff});
			acc(1'b0, 12'h800, 13'h0800);
		end
		// vectors stay fixed with bank 3 selected
		for (int v = 0; v < 12; v++) begin
			pc = 12'hff4 + 12'(v);
			acc(1'b0, pc, {1'b0, pc});
		end
		// window reads at both ends and inside
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 7'h7f : 7'($random(seed));
			wr_sel(2'($random(seed)), w);
			pc = (i < 2) ? 12'h040 : (i < 4) ? 12'h07f : 12'h040 | 12'($random(seed) & 63);
			acc(1'b1, pc, {w, pc[5:0]});
		end
		// addresses outside the window go to normal decode
		for (int k = 0; k < 4; k++) begin
			drd_req <= 1'b1;
			drd_addr <= (k == 0) ? 8'h3f : (k == 1) ? 8'h80 : (k == 2) ? 8'h00 : 8'hff;
			@(negedge core_clk);
			chk("ram_sel", 13'h1, {12'h0, ram_sel});
			@(negedge core_clk);
			chk("rom_en", 13'h0, {12'h0, rom_en});
			@(posedge core_clk);
			drd_req <= 1'b0;
			@(posedge core_clk);
		end
		// reset in mid-run clears both selections at once
		wr_sel(2'h3, 7'h7f);
		arst_n <= 1'b0;
		@(negedge core_clk);
		chk("bank_sel", 13'h0, {11'h0, bank_sel});
		chk("win_sel", 13'h0, {6'h0, win_sel});
		@(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		acc(1'b0, 12'h123, 13'h0123);
		acc(1'b1, 12'h045, 13'h0005);
		// a window read and a fetch asked together: the window read goes first
		fetch_req <= 1'b1;
		fetch_pc <= 12'h801;
		drd_req <= 1'b1;
		drd_addr <= 8'h41;
		@(negedge core_clk);
		chk("fetch_ready", 13'h0, {12'h0, fetch_ready});
		chk("drd_ready", 13'h1, {12'h0, drd_ready});
		@(posedge core_clk);
		drd_req <= 1'b0;
		@(negedge core_clk);
		chk("rom_addr", 13'h0001, rom_addr);
		chk("fetch_ready", 13'h0, {12'h0, fetch_ready});
		// the held fetch is taken once the window read has finished
		repeat (3) @(posedge core_clk);
		fetch_req <= 1'b0;
		@(negedge core_clk);
		chk("rom_en", 13'h1, {12'h0, rom_en});
		chk("rom_addr", 13'h0801, rom_addr);
		repeat (3) @(posedge core_clk);
		final_report();
	end
endmodule : pmap_mapper_bench
